// ===== rtl/cafm_filter.v
/*
 * Acceptance filter match stage: sixteen filters, three masks, mask
 * source selection, filter enables and buffer pointers, with a plain
 * register port for software.
 * Assumes received identifiers arrive from logic on the same clock and
 * that software never writes the reserved mask source encoding.
 */
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "cafm_defs.vh"

// Functional notes
// R1 - Standard pattern in bits 15-5 of standard register must equal message.
// R2 - Extended upper bits in bits 1-0, lower sixteen in extended register.
// R3 - With type match, select bit set accepts extended only, clear standard.
// R4 - Without type match the filter's extended select bit is ignored.
// R5 - Bits 4 and 2 of standard pattern registers always read zero.
// R6 - Sixteen filters, each with read-write standard and extended registers.
// R7 - Mask source 00, 01, 10 apply mask 0, 1, 2.
// R8 - Software never writes mask source value 11; it is reserved.
// R9 - Filters 0-7 selectors in low select register, filter 0 lowest.
// R10 - Filters 8-15 selectors in high select register, filter 8 lowest.
// R11 - Set mask bit includes identifier bit; cleared bit is don't care.
// R12 - Mask type-match bit restricts match to filter's message type.
// R13 - Only enabled filters may produce a hit.
// R14 - A hit routes to the filter's 4-bit buffer pointer; 1111 is FIFO.
// R15 - Hit needs enable, all masked bits equal, and type condition.
// R16 - Mask source selectors reset to zero, selecting mask 0.
module cafm_filter
#(
    parameter NUM_FILTERS = 16,
    parameter COUNT_W = 16
)
(
    input wire clock,
    input wire resetn,
    input wire [5:0] reg_addr,
    input wire [15:0] reg_write_data,
    input wire reg_write_strobe,
    input wire reg_read_strobe,
    output reg [15:0] reg_read_data,
    input wire id_valid,
    input wire [10:0] id_std_id_bits,
    input wire [17:0] id_ext_id_bits,
    input wire id_is_ext,
    output reg match_valid,
    output reg match_hit,
    output reg [3:0] match_filter,
    output reg [3:0] filter_buffer_pointer
);

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
reg [15:0] std_pat [0:15];
reg [15:0] ext_pat [0:15];
reg [15:0] mask_word [0:5];
reg [15:0] filter_mask_select_low;
reg [15:0] filter_mask_select_high;
reg [15:0] filter_accept_enable;
reg [15:0] bptr [0:3];
reg [COUNT_W-1:0] hit_count;
reg last_hit;
reg [3:0] last_filter;
reg [3:0] last_bptr;

wire [31:0] msel_all;
wire [95:0] mask_words;
wire [NUM_FILTERS-1:0] hits;
wire [63:0] bptr_all;

assign msel_all = {filter_mask_select_high, filter_mask_select_low}; // R9 R10
assign mask_words = {mask_word[5], mask_word[4], mask_word[3],
    mask_word[2], mask_word[1], mask_word[0]};
assign bptr_all = {bptr[3], bptr[2], bptr[1], bptr[0]};

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
wire sel_std;
wire sel_ext;
wire sel_bptr;
wire sel_mask;
wire [3:0] fidx;
wire [5:0] bidx;
wire [5:0] midx;
wire sel_msel_low;
wire sel_msel_high;
wire sel_acc_en;

assign sel_std = (reg_addr[5:4] == 2'h0);
assign sel_msel_low = (reg_addr == `CAFM_MSEL_LOW);
assign sel_msel_high = (reg_addr == `CAFM_MSEL_HIGH);
assign sel_acc_en = (reg_addr == `CAFM_ACC_EN);
assign sel_ext = (reg_addr[5:4] == 2'h1);
assign fidx = reg_addr[3:0];
assign bidx = reg_addr - `CAFM_BPTR_BASE;
assign midx = reg_addr - `CAFM_MASK_BASE;
assign sel_bptr = (reg_addr >= `CAFM_BPTR_BASE)
    && (reg_addr < `CAFM_MASK_BASE);
assign sel_mask = (reg_addr >= `CAFM_MASK_BASE)
    && (reg_addr < `CAFM_STATUS);

// ----------------------------------------------------------------
// Register write enables
// ----------------------------------------------------------------
wire wr_std;
wire wr_ext;
wire wr_bptr;
wire wr_mask;
wire wr_msel_low;
wire wr_msel_high;
wire wr_acc_en;

assign wr_std = reg_write_strobe & sel_std;
assign wr_ext = reg_write_strobe & sel_ext;
assign wr_bptr = reg_write_strobe & sel_bptr;
assign wr_mask = reg_write_strobe & sel_mask;
assign wr_msel_low = reg_write_strobe & sel_msel_low;
assign wr_msel_high = reg_write_strobe & sel_msel_high;
assign wr_acc_en = reg_write_strobe & sel_acc_en;

// ----------------------------------------------------------------
// Filter identifier patterns
// ----------------------------------------------------------------
integer i;

always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        for (i = 0; i < 16; i = i + 1)
        begin
            std_pat[i] <= `CAFM_RST_PAT;
            ext_pat[i] <= `CAFM_RST_PAT;
        end
    end
    else if (wr_std)
    begin
        std_pat[fidx] <= reg_write_data & `CAFM_STD_WMASK; // R5 R6
    end
    else if (wr_ext)
    begin
        ext_pat[fidx] <= reg_write_data; // R6
    end
end

// ----------------------------------------------------------------
// Acceptance masks and buffer pointers
// ----------------------------------------------------------------
integer j;

always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        for (j = 0; j < 6; j = j + 1)
        begin
            mask_word[j] <= `CAFM_RST_PAT;
        end
        for (j = 0; j < 4; j = j + 1)
        begin
            bptr[j] <= `CAFM_RST_BPTR;
        end
    end
    else if (wr_bptr)
    begin
        bptr[bidx[1:0]] <= reg_write_data;
    end
    else if (wr_mask)
    begin
        mask_word[midx[2:0]] <= reg_write_data & `CAFM_STD_WMASK
            | (midx[0] ? reg_write_data : 16'h0000);
    end
end

// ----------------------------------------------------------------
// Mask source selects and filter enables
// ----------------------------------------------------------------
always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        filter_mask_select_low <= `CAFM_RST_MSEL; // R16
        filter_mask_select_high <= `CAFM_RST_MSEL; // R16
        filter_accept_enable <= `CAFM_RST_ACC_EN;
    end
    else
    begin
        if (wr_msel_low)
            filter_mask_select_low <= reg_write_data; // R9
        if (wr_msel_high)
            filter_mask_select_high <= reg_write_data; // R10
        if (wr_acc_en)
            filter_accept_enable <= reg_write_data; // R13
    end
end

// ----------------------------------------------------------------
// Register reads
// ----------------------------------------------------------------
reg [15:0] next_read_data;
wire [15:0] status_word;

assign status_word = {7'h00, last_hit, last_bptr, last_filter};

always @*
begin
    next_read_data = 16'h0000;
    if (sel_std)
        next_read_data = std_pat[fidx] & `CAFM_STD_WMASK; // R5
    else if (sel_ext)
        next_read_data = ext_pat[fidx];
    else if (sel_bptr)
        next_read_data = bptr[bidx[1:0]];
    else if (sel_mask)
        next_read_data = mask_word[midx[2:0]];
    else
    begin
        case (reg_addr)
            `CAFM_MSEL_LOW:
                next_read_data = filter_mask_select_low;
            `CAFM_MSEL_HIGH:
                next_read_data = filter_mask_select_high;
            `CAFM_ACC_EN:
                next_read_data = filter_accept_enable;
            `CAFM_STATUS:
                next_read_data = status_word;
            `CAFM_HIT_COUNT:
                next_read_data = hit_count[15:0];
            default:
                next_read_data = 16'h0000;
        endcase
    end
end

always @(posedge clock or negedge resetn)
begin
    if (!resetn)
        reg_read_data <= 16'h0000;
    else if (reg_read_strobe)
        reg_read_data <= next_read_data;
    else
        reg_read_data <= 16'h0000;
end

// ----------------------------------------------------------------
// Filter comparators
// ----------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < NUM_FILTERS; g = g + 1)
    begin : slot
        cafm_filter_slot u_slot
        (
            .std_pat(std_pat[g]),
            .ext_pat(ext_pat[g]),
            .filter_mask_source(msel_all[2*g+1:2*g]), // R7 R9 R10
            .mask_words(mask_words),
            .filter_accept_enable(filter_accept_enable[g]), // R13
            .msg_std_id_bits(id_std_id_bits),
            .msg_ext_id_bits(id_ext_id_bits),
            .msg_is_ext(id_is_ext),
            .hit(hits[g])
        );
    end
endgenerate

// ----------------------------------------------------------------
// Lowest numbered hitting filter wins
// ----------------------------------------------------------------
reg any_hit;
reg [3:0] win_idx;
integer k;

always @*
begin
    any_hit = 1'b0;
    win_idx = 4'h0;
    for (k = NUM_FILTERS - 1; k >= 0; k = k - 1)
    begin
        if (hits[k])
        begin
            any_hit = 1'b1; // R15
            win_idx = k[3:0];
        end
    end
end

wire [3:0] win_bptr;
assign win_bptr = bptr_all[{win_idx, 2'b00} +: 4]; // R14

// ----------------------------------------------------------------
// Match result
// ----------------------------------------------------------------
always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        match_valid <= 1'b0;
        match_hit <= 1'b0;
    end
    else
    begin
        match_valid <= id_valid;
        match_hit <= id_valid & any_hit; // R15
    end
end

always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        match_filter <= 4'h0;
        filter_buffer_pointer <= 4'h0;
    end
    else if (id_valid)
    begin
        match_filter <= win_idx;
        filter_buffer_pointer <= win_bptr; // R14
    end
end

// ----------------------------------------------------------------
// Last result and hit counter
// ----------------------------------------------------------------
always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        last_hit <= 1'b0;
        last_filter <= 4'h0;
        last_bptr <= 4'h0;
        hit_count <= {COUNT_W{1'b0}};
    end
    else if (id_valid)
    begin
        last_hit <= any_hit;
        last_filter <= win_idx;
        last_bptr <= win_bptr;
        if (any_hit)
            hit_count <= hit_count + {{(COUNT_W-1){1'b0}}, 1'b1};
    end
end

endmodule

// ===== common/cafm_defs.vh
/*
 * Register map, field positions, reset values and encodings for the
 * acceptance filter match block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CAFM_DEFS_VH
`define CAFM_DEFS_VH

// ----------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------
`define CAFM_ADDR_W 6
`define CAFM_STD_BASE 6'h00
`define CAFM_EXT_BASE 6'h10
`define CAFM_MSEL_LOW 6'h20
`define CAFM_MSEL_HIGH 6'h21
`define CAFM_ACC_EN 6'h22
`define CAFM_BPTR_BASE 6'h23
`define CAFM_MASK_BASE 6'h27
`define CAFM_STATUS 6'h2D
`define CAFM_HIT_COUNT 6'h2E

// ----------------------------------------------------------------
// Identifier register fields
// ----------------------------------------------------------------
`define CAFM_SID_HI 15
`define CAFM_SID_LO 5
`define CAFM_XSEL_BIT 3
`define CAFM_EIDU_HI 1
`define CAFM_EIDU_LO 0
`define CAFM_STD_WMASK 16'hFFEB

// ----------------------------------------------------------------
// Mask source encodings
// ----------------------------------------------------------------
`define CAFM_MSRC_M0 2'h0
`define CAFM_MSRC_M1 2'h1
`define CAFM_MSRC_M2 2'h2
`define CAFM_MSRC_RSV 2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CAFM_RST_PAT 16'h0000
`define CAFM_RST_MSEL 16'h0000
`define CAFM_RST_ACC_EN 16'hFFFF
`define CAFM_RST_BPTR 16'h0000

`endif

// ===== rtl/cafm_filter_slot.v
/*
 * One acceptance filter comparator: pattern, all three masks with the
 * mask source select, enable and the received identifier in, hit out.
 * Assumes all inputs are from the same clock domain; purely combinational.
 */
`timescale 1ns/1ps
`include "cafm_defs.vh"

module cafm_filter_slot
(
    input wire [15:0] std_pat,
    input wire [15:0] ext_pat,
    input wire [1:0] filter_mask_source,
    input wire [95:0] mask_words,
    input wire filter_accept_enable,
    input wire [10:0] msg_std_id_bits,
    input wire [17:0] msg_ext_id_bits,
    input wire msg_is_ext,
    output reg hit
);

// ----------------------------------------------------------------
// Mask selection and comparison
// ----------------------------------------------------------------
reg [15:0] mstd;
reg [15:0] mext;
reg msrc_ok;
reg [10:0] sid_diff;
reg [17:0] eid_diff;
reg type_ok;

always @*
begin
    msrc_ok = 1'b1;
    mstd = mask_words[15:0];
    mext = mask_words[31:16];
    case (filter_mask_source)
        `CAFM_MSRC_M0:
        begin
            mstd = mask_words[15:0]; // R7
            mext = mask_words[31:16];
        end
        `CAFM_MSRC_M1:
        begin
            mstd = mask_words[47:32]; // R7
            mext = mask_words[63:48];
        end
        `CAFM_MSRC_M2:
        begin
            mstd = mask_words[79:64]; // R7
            mext = mask_words[95:80];
        end
        default:
        begin
            msrc_ok = 1'b0;
        end
    endcase
    sid_diff = (std_pat[`CAFM_SID_HI:`CAFM_SID_LO] ^ msg_std_id_bits)
        & mstd[`CAFM_SID_HI:`CAFM_SID_LO]; // R1 R11
    eid_diff = ({std_pat[`CAFM_EIDU_HI:`CAFM_EIDU_LO], ext_pat}
        ^ msg_ext_id_bits)
        & {mstd[`CAFM_EIDU_HI:`CAFM_EIDU_LO], mext}; // R2 R11
    if (mstd[`CAFM_XSEL_BIT])
        type_ok = (std_pat[`CAFM_XSEL_BIT] == msg_is_ext); // R3 R12
    else
        type_ok = 1'b1; // R4
    hit = filter_accept_enable & msrc_ok & type_ok & (sid_diff == 11'h000)
        & (~msg_is_ext | (eid_diff == 18'h00000)); // R13 R15
end

endmodule

// ===== dv/cafm_filter_checker.sv
/* Port checker for the acceptance filter match stage.
   Assumes one clock and an active low asynchronous reset. */
`timescale 1ns/1ps
module cafm_filter_checker
(
    input wire clock,
    input wire resetn,
    input wire [5:0] reg_addr,
    input wire [15:0] reg_write_data,
    input wire reg_write_strobe,
    input wire reg_read_strobe,
    input wire [15:0] reg_read_data,
    input wire id_valid,
    input wire match_valid,
    input wire match_hit,
    input wire [3:0] match_filter,
    input wire [3:0] filter_buffer_pointer
);
    // ----------------------------------------
    // Port assertions
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    valid_follows_a: assert property (id_valid |=> match_valid)
        else $error("no answer after identifier");
    no_spurious_a: assert property (!id_valid |=> !match_valid)
        else $error("answer without identifier");
    hit_qualified_a: assert property (match_hit |-> match_valid)
        else $error("hit outside answer cycle");
    read_idle_a: assert property (!reg_read_strobe |=>
        reg_read_data == 16'h0000) else $error("read data not idle");
    std_readback_a: assert property (
        (reg_write_strobe && reg_addr < 6'h10) ##1
        (reg_read_strobe && reg_addr == $past(reg_addr)) |=>
        reg_read_data == ($past(reg_write_data, 2) & 16'hFFEB))
        else $error("standard pattern read back wrong");
    word_readback_a: assert property (
        (reg_write_strobe && reg_addr >= 6'h10 && reg_addr <= 6'h26) ##1
        (reg_read_strobe && reg_addr == $past(reg_addr)) |=>
        reg_read_data == $past(reg_write_data, 2))
        else $error("register read back wrong");
    unused_zero_a: assert property (reg_read_strobe && reg_addr < 6'h10
        |=> reg_read_data[4] == 1'b0 && reg_read_data[2] == 1'b0)
        else $error("unimplemented bits read as one");
    result_held_a: assert property (!id_valid |=>
        $stable(match_filter) && $stable(filter_buffer_pointer))
        else $error("result changed without identifier");
    cover property (match_valid && match_hit);
    cover property (match_valid && !match_hit);
    cover property (reg_read_strobe && reg_addr == 6'h22);
endmodule

bind cafm_filter cafm_filter_checker chk
(
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_write_data(reg_write_data), .reg_write_strobe(reg_write_strobe),
    .reg_read_strobe(reg_read_strobe), .reg_read_data(reg_read_data),
    .id_valid(id_valid), .match_valid(match_valid), .match_hit(match_hit),
    .match_filter(match_filter),
    .filter_buffer_pointer(filter_buffer_pointer)
);

// ===== dv/cafm_can_engine.sv
/* Model of the protocol engine that hands received identifiers over.
   Assumes tasks are called at a rising clock edge. */
`timescale 1ns/1ps
module cafm_can_engine
(
    input wire clock,
    output logic id_valid,
    output logic [10:0] id_std_id_bits,
    output logic [17:0] id_ext_id_bits,
    output logic id_is_ext
);
    initial
    begin
        id_valid = 1'b0;
        id_std_id_bits = 11'h000;
        id_ext_id_bits = 18'h00000;
        id_is_ext = 1'b0;
    end
    // One identifier per cycle, calls may run back to back
    task automatic deliver(input logic [10:0] s, input logic [17:0] e,
                           input logic x);
        id_valid <= 1'b1;
        id_std_id_bits <= s;
        id_ext_id_bits <= e;
        id_is_ext <= x;
        @(posedge clock);
    endtask
    // Released lines show the inverse of the last value
    task automatic quiet;
        id_valid <= 1'b0;
        id_std_id_bits <= ~id_std_id_bits;
        id_ext_id_bits <= ~id_ext_id_bits;
        id_is_ext <= ~id_is_ext;
        @(posedge clock);
    endtask
endmodule

// ===== dv/can_acceptance_filter_match_bench.sv
/* Self-checking bench for the acceptance filter match stage.
   Assumes the engine model and the bound checker. */
`timescale 1ns/1ps
module can_acceptance_filter_match_bench;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [15:0] reg_write_data = 16'h0000;
    logic reg_write_strobe = 1'b0;
    logic reg_read_strobe = 1'b0;
    logic [15:0] reg_read_data;
    logic [15:0] d;
    wire id_valid;
    wire id_is_ext;
    wire [10:0] id_std_id_bits;
    wire [17:0] id_ext_id_bits;
    logic match_valid;
    logic match_hit;
    logic [3:0] match_filter;
    logic [3:0] filter_buffer_pointer;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [8:0] expq [$];
    logic [8:0] e;
    logic [21:0] cfg [0:16] = '{{6'h27, 16'hFFE3}, {6'h28, 16'hFFFF},
        {6'h29, 16'hFFE0}, {6'h2A, 16'h0000}, {6'h2B, 16'hFFEB},
        {6'h2C, 16'hFFFF}, {6'h03, 16'h2468}, {6'h09, 16'hFFEA},
        {6'h19, 16'hABCD}, {6'h0C, 16'h0AA0}, {6'h1C, 16'h0000},
        {6'h20, 16'h0040}, {6'h21, 16'h0008}, {6'h23, 16'hF000},
        {6'h25, 16'h00E0}, {6'h26, 16'h0005}, {6'h22, 16'h1208}};
    // Identifier in, then expected hit, filter and pointer
    logic [38:0] rows [0:8] = '{
        {11'h123, 18'h00000, 1'h0, 1'h1, 4'h3, 4'hF},
        {11'h123, 18'h3FFFF, 1'h1, 1'h1, 4'h3, 4'hF},
        {11'h122, 18'h00000, 1'h0, 1'h0, 4'h0, 4'h0},
        {11'h7FF, 18'h2ABCD, 1'h1, 1'h1, 4'h9, 4'hE},
        {11'h7FF, 18'h2ABCD, 1'h0, 1'h0, 4'h0, 4'h0},
        {11'h7FF, 18'h0ABCD, 1'h1, 1'h0, 4'h0, 4'h0},
        {11'h7FF, 18'h2ABCC, 1'h1, 1'h0, 4'h0, 4'h0},
        {11'h055, 18'h00000, 1'h0, 1'h1, 4'hC, 4'h5},
        {11'h055, 18'h00001, 1'h1, 1'h0, 4'h0, 4'h0}};

    always #4 clock = ~clock;

    cafm_can_engine eng (.clock(clock), .id_valid(id_valid),
        .id_std_id_bits(id_std_id_bits), .id_ext_id_bits(id_ext_id_bits),
        .id_is_ext(id_is_ext));
    cafm_filter uut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_write_data(reg_write_data), .reg_write_strobe(reg_write_strobe),
        .reg_read_strobe(reg_read_strobe), .reg_read_data(reg_read_data),
        .id_valid(id_valid), .id_std_id_bits(id_std_id_bits),
        .id_ext_id_bits(id_ext_id_bits), .id_is_ext(id_is_ext),
        .match_valid(match_valid), .match_hit(match_hit),
        .match_filter(match_filter),
        .filter_buffer_pointer(filter_buffer_pointer));

    // ----------------------------------------
    // Compare, bus and closing tasks
    // ----------------------------------------
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: word %h, want %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: flag %b, want %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        reg_read_strobe <= 1'b0;
        reg_addr <= a;
        reg_write_data <= v;
        reg_write_strobe <= 1'b1;
        @(posedge clock);
    endtask
    task automatic rd(input logic [5:0] a);
        reg_write_strobe <= 1'b0;
        reg_addr <= a;
        reg_read_strobe <= 1'b1;
        @(posedge clock);
        reg_read_strobe <= 1'b0;
        @(negedge clock);
        d = reg_read_data;
        @(posedge clock);
    endtask
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(negedge clock)
        if (match_valid === 1'b1)
        begin
            e = expq.pop_front();
            chk_bit(match_hit, e[8]);
            if (e[8])
            begin
                chk_word({12'h000, match_filter}, {12'h000, e[7:4]});
                chk_word({12'h000, filter_buffer_pointer},
                    {12'h000, e[3:0]});
            end
        end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fails++;
            end_sim;
        end
    end

    initial
    begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        foreach (cfg[i]) wr(cfg[i][21:16], cfg[i][15:0]);
        foreach (cfg[i])
        begin
            rd(cfg[i][21:16]);
            chk_word(d, cfg[i][15:0]);
        end
        foreach (rows[i])
        begin
            eng.deliver(rows[i][38:28], rows[i][27:10], rows[i][9]);
            expq.push_back(rows[i][8:0]);
        end
        eng.quiet();
        @(posedge clock);
        chk_bit(expq.size() == 0, 1'b1);
        rd(6'h2E);
        chk_word(d, 16'h0004);
        $display("test table done");
        wr(6'h05, 16'hFFFF);
        rd(6'h05);
        chk_word(d, 16'hFFEB);
        wr(6'h3F, 16'hFFFF);
        rd(6'h3F);
        chk_word(d, 16'h0000);
        wr(6'h22, 16'h1200);
        rd(6'h22);
        chk_word(d, 16'h1200);
        eng.deliver(11'h123, 18'h00000, 1'b0);
        expq.push_back(9'h000);
        eng.quiet();
        $display("test access and enable done");
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        rd(6'h20);
        chk_word(d, 16'h0000);
        rd(6'h21);
        chk_word(d, 16'h0000);
        rd(6'h22);
        chk_word(d, 16'hFFFF);
        eng.deliver(11'h7FF, 18'h3FFFF, 1'b1);
        expq.push_back({1'b1, 4'h0, 4'h0});
        eng.quiet();
        @(posedge clock);
        rd(6'h2D);
        chk_word(d, 16'h0100);
        rd(6'h2E);
        chk_word(d, 16'h0001);
        chk_bit(expq.size() == 0, 1'b1);
        $display("test second reset done");
        end_sim;
    end
endmodule
